// file: logic/pwr_seq_regs.svh
// Timing constants and cycle scale factors for the power, reset and hibernate sequencer
`ifndef PWR_SEQ_REGS_SVH
`define PWR_SEQ_REGS_SVH
`define CLK_PERIOD_NS 10
`define HW_WAKE_MS 25
`define ROM_INIT_MS 1100
`define HIB_WAKE_MS 50
`define HIB_CAL_MS 200
`define HIB_PATCH_MS 75
`define HIB_MIN_MS 10
`define LOAD_US_PER_KB 60
`define CAL_TEMP_DELTA_C 20
`define CAL_AGE_HOURS 24
`define CYC_PER_US (1000 / `CLK_PERIOD_NS)
`define CYC_PER_MS (1000 * `CYC_PER_US)
`endif

// file: logic/pwr_seq_pkg.sv
// Types for the power, reset and hibernate sequencer
`default_nettype none
package pwr_seq_pkg;
  typedef enum logic [2:0] {
    ST_RESET_HOLD, ST_HW_WAKE, ST_ROM_INIT, ST_APP_LOAD, ST_RUN, ST_HIBERNATE, ST_HIB_WAKE
  } seq_state_e;
  typedef struct packed {
    logic running;
    logic in_hibernate;
    logic osc_enable;
    logic cal_active;
  } seq_status_s;
endpackage : pwr_seq_pkg
`default_nettype wire

// file: logic/power_reset_hibernate_seq.sv
// Start-up, restart and hibernate-exit sequencer
// Contract
// R1 - Host holds reset low during supply ramp
// R2 - Host releases reset 1 ms after supplies
// R3 - Wake 25 ms, then ROM init 1.1 s
// R4 - Image load takes size KB times 0.06 ms
// R5 - Pins held steady 200 ms before power-off
// R6 - Restart needs reset pulse of 200 ms
// R7 - Slow crystal stays on in hibernate
// R8 - Hibernate lasts at least 10 ms
// R9 - Hibernate exit takes 50 ms before load
// R10 - Calibration stretches hibernate exit to 200 ms
// R11 - Flash patch stretches hibernate exit to 75 ms
// R12 - Phases run in order; reset returns hold
// R13 - Application ready only after all phases
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_regs.svh"
module power_reset_hibernate_seq #(
  parameter int HW_WAKE_CYC = `HW_WAKE_MS * `CYC_PER_MS,
  parameter int ROM_INIT_CYC = `ROM_INIT_MS * `CYC_PER_MS,
  parameter int HIB_WAKE_CYC = `HIB_WAKE_MS * `CYC_PER_MS,
  parameter int HIB_CAL_CYC = `HIB_CAL_MS * `CYC_PER_MS,
  parameter int HIB_PATCH_CYC = `HIB_PATCH_MS * `CYC_PER_MS,
  parameter int HIB_MIN_CYC = `HIB_MIN_MS * `CYC_PER_MS,
  parameter int LOAD_CYC_PER_KB = `LOAD_US_PER_KB * `CYC_PER_US,
  parameter int KB_W = 11
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic module_reset_n,
  input wire logic hibernate_request_n,
  input wire logic sw_hibernate,
  input wire logic cal_due,
  input wire logic patch_pending,
  input wire logic [KB_W-1:0] image_kb,
  output logic app_ready,
  output logic slow_crystal_osc_en,
  output pwr_seq_pkg::seq_status_s status,
  output pwr_seq_pkg::seq_state_e phase
);
  import pwr_seq_pkg::*;

  // Elaboration check of parameters
  if (KB_W < 1 || KB_W > 16 || HW_WAKE_CYC < 1 || ROM_INIT_CYC < 1 || HIB_WAKE_CYC < 1 ||
      HIB_CAL_CYC < HIB_WAKE_CYC || HIB_PATCH_CYC < HIB_WAKE_CYC || HIB_MIN_CYC < 1 ||
      LOAD_CYC_PER_KB < 1) begin : g_bad_param
    $error("power_reset_hibernate_seq: bad parameter");
  end

  logic rst_s1, rst_s2, hib_s1, hib_s2;
  seq_state_e state_reg;
  logic [31:0] cnt_reg;
  logic [31:0] target_reg;
  logic [31:0] load_cyc;
  logic [31:0] exit_cyc;
  logic done;

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
      hib_s1 <= 1'b1;
      hib_s2 <= 1'b1;
    end else begin
      rst_s1 <= module_reset_n;
      rst_s2 <= rst_s1;
      hib_s1 <= hibernate_request_n;
      hib_s2 <= hib_s1;
    end
  end

  assign load_cyc = 32'(image_kb) * 32'(LOAD_CYC_PER_KB); // R4
  always_comb begin
    exit_cyc = 32'(HIB_WAKE_CYC); // R9
    if (patch_pending) exit_cyc = 32'(HIB_PATCH_CYC); // R11
    if (cal_due) exit_cyc = 32'(HIB_CAL_CYC); // R10
  end
  assign done = (cnt_reg + 32'h0000_0001) >= target_reg;

  // Phase sequencing
  always_ff @(posedge clk) begin
    if (sys_rst || !rst_s2) begin
      state_reg <= ST_RESET_HOLD; // R12
      cnt_reg <= 32'h0000_0000;
      target_reg <= 32'h0000_0000;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
      case (state_reg)
        ST_RESET_HOLD: begin
          state_reg <= ST_HW_WAKE; // R3
          cnt_reg <= 32'h0000_0000;
          target_reg <= 32'(HW_WAKE_CYC);
        end
        ST_HW_WAKE: if (done) begin
          state_reg <= ST_ROM_INIT; // R3
          cnt_reg <= 32'h0000_0000;
          target_reg <= 32'(ROM_INIT_CYC);
        end
        ST_ROM_INIT, ST_HIB_WAKE: if (done) begin
          cnt_reg <= 32'h0000_0000;
          target_reg <= load_cyc; // R4
          state_reg <= (load_cyc == 32'h0000_0000) ? ST_RUN : ST_APP_LOAD;
        end
        ST_APP_LOAD: if (done) begin
          state_reg <= ST_RUN; // R13
          cnt_reg <= 32'h0000_0000;
        end
        ST_RUN: begin
          cnt_reg <= 32'h0000_0000;
          if (sw_hibernate || !hib_s2) begin
            state_reg <= ST_HIBERNATE;
            target_reg <= 32'(HIB_MIN_CYC);
          end
        end
        ST_HIBERNATE: begin
          if (!done) begin
            cnt_reg <= cnt_reg + 32'h0000_0001; // R8
          end else if (hib_s2 && !sw_hibernate) begin
            state_reg <= ST_HIB_WAKE; // R9
            cnt_reg <= 32'h0000_0000;
            target_reg <= exit_cyc;
          end else begin
            cnt_reg <= cnt_reg;
          end
        end
        default: state_reg <= ST_RESET_HOLD;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      app_ready <= 1'b0;
      slow_crystal_osc_en <= 1'b1;
      status <= '0;
      phase <= ST_RESET_HOLD;
    end else begin
      app_ready <= (state_reg == ST_RUN); // R13
      slow_crystal_osc_en <= 1'b1; // R7
      status.running <= (state_reg == ST_RUN);
      status.in_hibernate <= (state_reg == ST_HIBERNATE);
      status.osc_enable <= 1'b1; // R7
      status.cal_active <= (state_reg == ST_HIB_WAKE) && (target_reg == 32'(HIB_CAL_CYC));
      phase <= state_reg;
    end
  end

  // Checks
  property p_reset_hold;
    @(posedge clk) disable iff (sys_rst) !rst_s2 |=> state_reg == ST_RESET_HOLD;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset did not hold"); // R12
  property p_wake_to_init;
    @(posedge clk) disable iff (sys_rst || !rst_s2)
      state_reg == ST_HW_WAKE && $past(state_reg) == ST_RESET_HOLD |-> target_reg == 32'(HW_WAKE_CYC);
  endproperty
  a_wake_to_init: assert property (p_wake_to_init) else $error("wake time wrong"); // R3
  property p_init_from_wake;
    @(posedge clk) disable iff (sys_rst || !rst_s2)
      state_reg == ST_ROM_INIT && $past(state_reg) != ST_ROM_INIT |-> $past(state_reg) == ST_HW_WAKE;
  endproperty
  a_init_from_wake: assert property (p_init_from_wake) else $error("order broken"); // R12
  property p_load_len;
    @(posedge clk) disable iff (sys_rst || !rst_s2)
      state_reg == ST_APP_LOAD && $past(state_reg) != ST_APP_LOAD |-> target_reg == $past(load_cyc);
  endproperty
  a_load_len: assert property (p_load_len) else $error("load time wrong"); // R4
  property p_ready;
    @(posedge clk) disable iff (sys_rst) app_ready |-> $past(state_reg) == ST_RUN;
  endproperty
  a_ready: assert property (p_ready) else $error("ready too early"); // R13
  property p_osc;
    @(posedge clk) disable iff (sys_rst) status.in_hibernate |-> slow_crystal_osc_en;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator off in hibernate"); // R7
  property p_hib_min;
    @(posedge clk) disable iff (sys_rst || !rst_s2)
      state_reg == ST_HIB_WAKE && $past(state_reg) == ST_HIBERNATE |-> $past(cnt_reg) + 32'h1 >= 32'(HIB_MIN_CYC);
  endproperty
  a_hib_min: assert property (p_hib_min) else $error("hibernate too short"); // R8
  property p_exit_len;
    @(posedge clk) disable iff (sys_rst || !rst_s2)
      state_reg == ST_HIB_WAKE && $past(state_reg) == ST_HIBERNATE |->
      target_reg == ($past(cal_due) ? 32'(HIB_CAL_CYC) :
                     $past(patch_pending) ? 32'(HIB_PATCH_CYC) : 32'(HIB_WAKE_CYC));
  endproperty
  a_exit_len: assert property (p_exit_len) else $error("exit time wrong"); // R9 R10 R11
  property p_hw_wake_len;
    @(posedge clk) disable iff (sys_rst || !rst_s2)
      state_reg == ST_ROM_INIT && $past(state_reg) == ST_HW_WAKE |->
      $past(cnt_reg) + 32'h0000_0001 == 32'(HW_WAKE_CYC);
  endproperty
  a_hw_wake_len: assert property (p_hw_wake_len) else $error("wake phase length wrong"); // R3
  property p_rom_init_len;
    @(posedge clk) disable iff (sys_rst || !rst_s2)
      state_reg != ST_ROM_INIT && $past(state_reg) == ST_ROM_INIT |->
      $past(cnt_reg) + 32'h0000_0001 == 32'(ROM_INIT_CYC);
  endproperty
  a_rom_init_len: assert property (p_rom_init_len) else $error("init phase length wrong"); // R3
  property p_load_done;
    @(posedge clk) disable iff (sys_rst || !rst_s2)
      state_reg == ST_RUN && $past(state_reg) == ST_APP_LOAD |->
      $past(cnt_reg) + 32'h0000_0001 == $past(target_reg);
  endproperty
  a_load_done: assert property (p_load_done) else $error("load ended early"); // R4
  property p_hib_exit_done;
    @(posedge clk) disable iff (sys_rst || !rst_s2)
      state_reg != ST_HIB_WAKE && $past(state_reg) == ST_HIB_WAKE |->
      $past(cnt_reg) + 32'h0000_0001 == $past(target_reg);
  endproperty
  a_hib_exit_done: assert property (p_hib_exit_done) else $error("exit ended early"); // R9
  property p_run_order;
    @(posedge clk) disable iff (sys_rst || !rst_s2)
      state_reg == ST_RUN && $past(state_reg) != ST_RUN |->
      $past(state_reg) inside {ST_APP_LOAD, ST_ROM_INIT, ST_HIB_WAKE};
  endproperty
  a_run_order: assert property (p_run_order) else $error("run entered out of order"); // R12
  property p_hib_hold;
    @(posedge clk) disable iff (sys_rst || !rst_s2)
      state_reg == ST_HIBERNATE && (sw_hibernate || !hib_s2) |=> state_reg == ST_HIBERNATE;
  endproperty
  a_hib_hold: assert property (p_hib_hold) else $error("left hibernate while held"); // R8
  c_boot: cover property (@(posedge clk) disable iff (sys_rst) $rose(app_ready));
  c_hib: cover property (@(posedge clk) disable iff (sys_rst) state_reg == ST_HIBERNATE);
  c_cal: cover property (@(posedge clk) disable iff (sys_rst) status.cal_active);
  c_patch: cover property (@(posedge clk) disable iff (sys_rst)
    state_reg == ST_HIB_WAKE && target_reg == 32'(HIB_PATCH_CYC));
endmodule : power_reset_hibernate_seq
`default_nettype wire

// file: dv/host_ctrl_model.sv
// Host model driving the module reset and hibernate pins
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model #(
  parameter int SETTLE_CYC = 5,
  parameter int PULSE_CYC = 20
) (
  input wire logic clk,
  output logic module_reset_n,
  output logic hibernate_request_n
);
  initial begin
    module_reset_n = 1'b0;
    hibernate_request_n = 1'b1;
  end
  task automatic set_pins(input logic rst_n, input logic hib_n, input int cyc);
    repeat (cyc) @(posedge clk);
    #1;
    module_reset_n = rst_n;
    hibernate_request_n = hib_n;
  endtask : set_pins
  task automatic power_up();
    set_pins(1'b1, 1'b1, SETTLE_CYC);
  endtask : power_up
  task automatic restart();
    set_pins(1'b0, 1'b1, 1);
    set_pins(1'b1, 1'b1, PULSE_CYC);
  endtask : restart
endmodule : host_ctrl_model
`default_nettype wire

// file: dv/power_reset_hibernate_seq_bench.sv
// Bench for the power, reset and hibernate sequencer
`timescale 1ns/1ps
`default_nettype none
module power_reset_hibernate_seq_bench;
  import pwr_seq_pkg::*;
  localparam int HW = 20, ROM = 30, HWK = 10, PAT = 15, CAL = 20, HMIN = 5, LPK = 2;
  logic clk = 0, sys_rst = 1, sw_hibernate = 0, cal_due = 0, patch_pending = 0;
  logic [10:0] image_kb = '0;
  logic module_reset_n, hibernate_request_n, app_ready, slow_crystal_osc_en;
  seq_status_s status;
  seq_state_e phase;
  int num_errors = 0, comparisons = 0, cyc = 0, t0 = 0, e = 0;
  int exp_q[$];
  int wake_t[3] = '{HWK, PAT, CAL};
  power_reset_hibernate_seq #(.HW_WAKE_CYC(HW), .ROM_INIT_CYC(ROM), .HIB_WAKE_CYC(HWK),
    .HIB_CAL_CYC(CAL), .HIB_PATCH_CYC(PAT), .HIB_MIN_CYC(HMIN), .LOAD_CYC_PER_KB(LPK))
  u_power_reset_hibernate_seq (.clk, .sys_rst, .module_reset_n, .hibernate_request_n,
    .sw_hibernate, .cal_due, .patch_pending, .image_kb, .app_ready, .slow_crystal_osc_en,
    .status, .phase);
  host_ctrl_model u_host_ctrl_model (.clk, .module_reset_n, .hibernate_request_n);
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check
  task automatic conclude();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic wait_ready();
    int n;
    n = 0;
    while (app_ready !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    #1;
    check(phase, ST_RUN, "not running");
    check(status.running, 1'b1, "running flag low");
  endtask : wait_ready
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 6000) begin
      num_errors++;
      conclude();
    end
  end
  always @(posedge app_ready) begin
    #1;
    check(exp_q.size() != 0, 1'b1, "unexpected ready");
    e = exp_q.pop_front();
    check(cyc - t0 >= e && cyc - t0 <= e + 6, 1'b1, "ready latency");
  end
  initial begin
    void'($urandom(25799));
    repeat (20) @(posedge clk);
    #1;
    sys_rst = 0;
    image_kb = 11'($urandom % 7 + 1);
    exp_q.push_back(HW + ROM + image_kb * LPK);
    u_host_ctrl_model.power_up();
    t0 = cyc;
    wait_ready();
    t0 = cyc;
    exp_q.push_back(HMIN + HWK + image_kb * LPK);
    u_host_ctrl_model.set_pins(1'b1, 1'b0, 1);
    u_host_ctrl_model.set_pins(1'b1, 1'b1, 4);
    check(status.in_hibernate, 1'b1, "not hibernating");
    check(slow_crystal_osc_en, 1'b1, "osc off in hibernate");
    check(status.osc_enable, 1'b1, "osc flag low in hibernate");
    wait_ready();
    for (int k = 0; k < 3; k++) begin
      image_kb = 11'($urandom % 7);
      cal_due = (k == 2);
      patch_pending = (k > 0);
      sw_hibernate = 1;
      repeat (HMIN + 4) @(posedge clk);
      #1;
      exp_q.push_back(wake_t[k] + image_kb * LPK);
      sw_hibernate = 0;
      t0 = cyc;
      repeat (2) @(posedge clk);
      #1;
      check(status.cal_active, 32'(k == 2), "calibration flag");
      wait_ready();
    end
    u_host_ctrl_model.restart();
    u_host_ctrl_model.set_pins(1'b0, 1'b1, HW + 10);
    u_host_ctrl_model.set_pins(1'b0, 1'b1, 4);
    check(phase, ST_RESET_HOLD, "no abort");
    check(app_ready, 1'b0, "ready in hold");
    exp_q.push_back(HW + ROM + image_kb * LPK);
    u_host_ctrl_model.set_pins(1'b1, 1'b1, 1);
    t0 = cyc;
    wait_ready();
    conclude();
  end
endmodule : power_reset_hibernate_seq_bench
`default_nettype wire
